// ---- logic/ppio_top.sv ----
// Parallel port I/O block: six latched ports, one input-only port
module ppio_top (
    input  wire logic        pclk,          // Machine clock, 200 MHz
    input  wire logic        presetn,       // Async reset, low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB write
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic [47:0] pin_in,        // Pin levels, ports 0-5
    output logic      [47:0] pin_out,       // Pin output levels
    output logic      [47:0] pin_oe,        // Pin output enables
    output logic      [47:0] weak_pu,       // Weak pullup enables
    input  wire logic [7:0]  port6_in,      // Input-only port levels
    input  wire logic        external_access_pin_n, // Low: external code
    input  wire logic        pc_above_int,  // PC beyond internal code
    input  wire logic        mem_cycle,     // External data cycle
    input  wire logic        addr16,        // Cycle uses 16-bit address
    input  wire logic [7:0]  addr_hi,       // High address byte
    input  wire logic [7:0]  ad_lo,         // Low address / write data
    input  wire logic        ad_drive,      // Port 0 drives, else reads
    output logic      [7:0]  ad_in,         // Port 0 levels for bus
    input  wire logic [7:0]  alt_out,       // Port 3 alternate outputs
    output logic      [7:0]  alt_in         // Port 3 alternate inputs
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]  latch_reg [0:5];
    logic [3:0]  cnt_reg;
    logic        bus_sel_reg;
    logic        hi_drive_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [7:0]  ad_in_reg;
    logic [7:0]  alt_in_reg;
    logic [7:0]  src [0:5];
    logic [31:0] rd_val;
    logic        rd_err;
    logic        wr_err;
    logic        setup;
    logic        access;
    logic        wr_go;
    logic        kick;
    logic        drop;
    logic        sample;

    ////////////////////////////////////////////////////////////////////////
    // Single-bit update of a whole byte
    function automatic logic [7:0] bit_update(
        input logic [7:0] byte_in,
        input logic [2:0] pos,
        input logic [1:0] op,
        input logic       carry
    );
        logic [7:0] res;
        res = byte_in;
        case (ppio_pkg::ppio_bitop_e'(op))
            ppio_pkg::BOP_CLR:  res[pos] = 1'b0;
            ppio_pkg::BOP_SET:  res[pos] = 1'b1;
            ppio_pkg::BOP_CPL:  res[pos] = ~byte_in[pos];
            ppio_pkg::BOP_MOVC: res[pos] = carry;
            default:            res[pos] = byte_in[pos];
        endcase
        return res;
    endfunction : bit_update

    ////////////////////////////////////////////////////////////////////////
    // Machine cycle: 12 clocks, count 0 is state1_phase1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 4'h0;
        else if (cnt_reg == ppio_pkg::CYC_LAST)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_reg + 4'h1;
    end

    // Edges that enter a phase 1 are the buffer sampling edges
    assign sample = cnt_reg[0];
    assign kick   = (cnt_reg == ppio_pkg::CYC_LAST);
    assign drop   = (cnt_reg == ppio_pkg::SLOT_STATE1_PHASE2);

    ////////////////////////////////////////////////////////////////////////
    // APB request decode
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    // Writes land only on the edge entering state6_phase2
    assign wr_go  = access & pwrite & pready_reg;

    // Read path: pin offsets read pins, latch offsets read latches
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b1;
        for (int i = 0; i < ppio_pkg::NUM_PORTS; i++)
        begin
            if (paddr == 8'(ppio_pkg::OFS_PIN0 + 4 * i))
            begin
                rd_val[7:0] = pin_in[i*8 +: 8];
                rd_err      = 1'b0;
            end
            if (paddr == 8'(ppio_pkg::OFS_LATCH0 + 4 * i))
            begin
                rd_val[7:0] = latch_reg[i];
                rd_err      = 1'b0;
            end
        end
        if (paddr == ppio_pkg::OFS_PORT6)
        begin
            rd_val[7:0] = port6_in;
            rd_err      = 1'b0;
        end
        if (paddr == ppio_pkg::OFS_STATUS)
        begin
            rd_val[1:0] = {hi_drive_reg, bus_sel_reg};
            rd_err      = 1'b0;
        end
        if (paddr == ppio_pkg::OFS_BITOP)
            rd_err = 1'b0;
    end

    // Write path: latch bytes and the bit-op word only
    always_comb
    begin
        wr_err = 1'b1;
        for (int i = 0; i < ppio_pkg::NUM_PORTS; i++)
            if (paddr == 8'(ppio_pkg::OFS_PIN0 + 4 * i))
                wr_err = 1'b0;
        if (paddr == ppio_pkg::OFS_BITOP)
            wr_err = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: reads in one wait-free cycle, writes wait for the slot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else if (pready_reg)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else if (setup && !pwrite)
        begin
            // The input-only port is sampled as one byte here
            pready_reg  <= 1'b1;
            pslverr_reg <= rd_err;
            prdata_reg  <= rd_val;
        end
        else if (access && pwrite && cnt_reg == ppio_pkg::SLOT_PRE)
        begin
            pready_reg  <= 1'b1;
            pslverr_reg <= wr_err;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Port latches; bus mode overwrites port 0 with ones every cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < ppio_pkg::NUM_PORTS; i++)
                latch_reg[i] <= ppio_pkg::LATCH_RST;
        end
        else
        begin
            for (int i = 0; i < ppio_pkg::NUM_PORTS; i++)
            begin
                if (wr_go && paddr == 8'(ppio_pkg::OFS_PIN0 + 4 * i))
                    latch_reg[i] <= pwdata[7:0];
                // Read the latch byte, change one bit, write all back
                if (wr_go && paddr == ppio_pkg::OFS_BITOP &&
                    pwdata[ppio_pkg::BOP_PORT_LSB +: 3] == 3'(i))
                    latch_reg[i] <= bit_update(latch_reg[i],
                        pwdata[ppio_pkg::BOP_BIT_LSB +: 3],
                        pwdata[ppio_pkg::BOP_OP_LSB +: 2],
                        pwdata[ppio_pkg::BOP_CARRY]);
            end
            if (bus_sel_reg)
                latch_reg[0] <= 8'hFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus switch; port 2 is never written by the bus, only bypassed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_sel_reg  <= 1'b0;
            hi_drive_reg <= 1'b0;
        end
        else
        begin
            bus_sel_reg  <= mem_cycle | ~external_access_pin_n |
                            pc_above_int;
            hi_drive_reg <= (mem_cycle | ~external_access_pin_n |
                             pc_above_int) & addr16;
        end
    end

    // Driver sources per port
    always_comb
    begin
        for (int i = 0; i < ppio_pkg::NUM_PORTS; i++)
            src[i] = latch_reg[i];
        if (bus_sel_reg)
            src[0] = ad_lo;
        if (hi_drive_reg)
            src[2] = addr_hi;
        // A zero on either side pulls the pin low
        src[3] = latch_reg[3] & alt_out;
    end

    ////////////////////////////////////////////////////////////////////////
    // One driver per port; port 0 is open drain
    for (genvar g = 0; g < ppio_pkg::NUM_PORTS; g++)
    begin : g_port
        ppio_drv #(
            .QUASI     (g != 0)
        ) u_drv (
            .pclk      (pclk),
            .presetn   (presetn),
            .sample    (sample),
            .kick      (kick),
            .drop      (drop),
            .src       (src[g]),
            .bus_en    ((g == 0) ? bus_sel_reg
                                 : ((g == 2) ? hi_drive_reg : 1'b0)),
            .bus_float ((g == 0) ? ~ad_drive : 1'b0),
            .out_reg   (pin_out[g*8 +: 8]),
            .oe_reg    (pin_oe[g*8 +: 8]),
            .weak_reg  (weak_pu[g*8 +: 8])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels back to the bus and the alternate functions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ad_in_reg  <= 8'h00;
            alt_in_reg <= 8'hFF;
        end
        else
        begin
            ad_in_reg  <= pin_in[7:0];
            // Serial in, irq a/b, timer a/b follow bit order of port 3
            alt_in_reg <= pin_in[31:24];
        end
    end

    assign ad_in  = ad_in_reg;
    assign alt_in = alt_in_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_bitop_p4;
        wr_go && paddr == ppio_pkg::OFS_BITOP && pwdata[2:0] == 3'h4;
    endsequence

    a_latch_slot: assert property (
        $changed(latch_reg[1]) |-> $past(cnt_reg) == ppio_pkg::SLOT_WRITE)
        else $error("port 1 latch changed outside state6_phase2");

    a_phase1_only: assert property (
        $changed(pin_out[15:8]) |-> $past(cnt_reg[0]))
        else $error("port 1 output changed outside phase 1");

    a_strong_win: assert property (
        |(pin_oe[15:8] & pin_out[15:8]) |-> cnt_reg <= 4'h1)
        else $error("strong pullup outside first two phases");

    a_p0_ones: assert property (
        bus_sel_reg |=> latch_reg[0] == 8'hFF)
        else $error("port 0 latch not all ones in bus mode");

    // Drivers follow the bus switch only at the next phase 1 edge
    a_p0_opendrn: assert property (
        |(pin_out[7:0] & pin_oe[7:0])
        |-> $past(bus_sel_reg) || $past(bus_sel_reg, 2))
        else $error("port 0 drove a one outside bus mode");

    a_p3_gate: assert property (
        $past(cnt_reg[0]) && !$past(latch_reg[3][0])
        |-> pin_oe[24] && !pin_out[24])
        else $error("port 3 bit 0 not held low by latch");

    a_latch_read: assert property (
        setup && !pwrite && paddr == 8'(ppio_pkg::OFS_LATCH0 + 4)
        |=> pready && prdata[7:0] == $past(latch_reg[1]))
        else $error("latch read returned wrong value");

    a_port6_read: assert property (
        setup && !pwrite && paddr == ppio_pkg::OFS_PORT6
        |=> prdata[7:0] == $past(port6_in))
        else $error("input-only port read wrong");

    a_hi_byte: assert property (
        $past(cnt_reg[0] && hi_drive_reg)
        |-> pin_oe[23:16] == 8'hFF && pin_out[23:16] == $past(addr_hi))
        else $error("port 2 not driving high address");

    a_bitop_rmw: assert property (
        s_bitop_p4 |=> ((latch_reg[4] ^ $past(latch_reg[4])) &
            ~(8'h01 << $past(pwdata[5:3]))) == 8'h00)
        else $error("bit write disturbed other bits");

endmodule : ppio_top

// ---- logic/ppio_pkg.sv ----
// Shared constants for the parallel port I/O block
package ppio_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Port geometry
    localparam int PORT_W    = 8;
    localparam int NUM_PORTS = 6;
    localparam int PIN_W     = PORT_W * NUM_PORTS;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_PIN0   = 8'h00; // Pin read / latch write
    localparam logic [7:0] OFS_PORT6  = 8'h18; // Input-only levels
    localparam logic [7:0] OFS_LATCH0 = 8'h20; // Latch read
    localparam logic [7:0] OFS_BITOP  = 8'h38; // Single-bit update
    localparam logic [7:0] OFS_STATUS = 8'h3C; // Bus switch state

    // Bit-op word fields
    localparam int BOP_PORT_LSB = 0;
    localparam int BOP_BIT_LSB  = 3;
    localparam int BOP_OP_LSB   = 6;
    localparam int BOP_CARRY    = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset value and machine-cycle slots (12 clocks, STATE1_PHASE1 = count 0)
    localparam logic [7:0] LATCH_RST  = 8'hFF;
    localparam logic [3:0] CYC_LAST   = 4'hB; // state6_phase2
    localparam logic [3:0] SLOT_WRITE = 4'hA; // Edge that enters STATE6_PHASE2
    localparam logic [3:0] SLOT_PRE   = 4'h9; // Raise pready before it
    localparam logic [3:0] SLOT_STATE1_PHASE2  = 4'h1; // state1_phase2

    ////////////////////////////////////////////////////////////////////////
    // Alternate functions of the multifunction port (port 3)
    localparam int ALT_SER_IN  = 0;
    localparam int ALT_SER_OUT = 1;
    localparam int ALT_IRQ_A   = 2; // ext_irq_input_a
    localparam int ALT_IRQ_B   = 3; // ext_irq_input_b
    localparam int ALT_TMR_A   = 4; // timer_a_count_input
    localparam int ALT_TMR_B   = 5; // timer_b_count_input
    localparam int ALT_WR_N    = 6;
    localparam int ALT_RD_N    = 7;

    // Single-bit operations
    typedef enum logic [1:0] {
        BOP_CLR  = 2'b00,
        BOP_SET  = 2'b01,
        BOP_CPL  = 2'b10,
        BOP_MOVC = 2'b11
    } ppio_bitop_e;

endpackage : ppio_pkg

// ---- logic/ppio_drv.sv ----
// Output buffer and driver control for one 8-bit port
module ppio_drv #(
    parameter bit QUASI = 1'b1              // 1: quasi port, 0: open drain
) (
    input  wire logic       pclk,           // Clock
    input  wire logic       presetn,        // Async reset, low
    input  wire logic       sample,         // Phase 1 sampling edge
    input  wire logic       kick,           // Edge entering state1_phase1
    input  wire logic       drop,           // Edge leaving state1_phase2
    input  wire logic [7:0] src,            // Latch or bus value
    input  wire logic       bus_en,         // Driver switched to the bus
    input  wire logic       bus_float,      // Bus reading, release pins
    output logic      [7:0] out_reg,        // Pin output level
    output logic      [7:0] oe_reg,         // Pin output enable
    output logic      [7:0] weak_reg        // Weak pullup enable
);

    logic [7:0] held_reg;
    logic [7:0] strong_reg;
    logic [7:0] rise;
    logic [7:0] strong_next;

    ////////////////////////////////////////////////////////////////////////
    // Strong pullup only for two phases after a 0 to 1 change
    always_comb
    begin
        rise        = (QUASI && kick && !bus_en) ? (src & ~held_reg)
                                                  : 8'h00;
        strong_next = kick ? rise : (drop ? 8'h00 : strong_reg);
    end

    // Buffer samples only in phase 1 and holds through phase 2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_reg   <= ppio_pkg::LATCH_RST;
            strong_reg <= 8'h00;
            out_reg    <= QUASI ? 8'hFF : 8'h00;
            oe_reg     <= 8'h00;
            weak_reg   <= QUASI ? 8'hFF : 8'h00;
        end
        else if (sample)
        begin
            held_reg   <= src;
            strong_reg <= strong_next;
            if (bus_en)
            begin
                // Bus drives both levels; port 2 uses strong pullups
                out_reg  <= src;
                oe_reg   <= (QUASI || !bus_float) ? 8'hFF : 8'h00;
                weak_reg <= 8'h00;
            end
            else if (QUASI)
            begin
                out_reg  <= src;
                oe_reg   <= ~src | strong_next;
                weak_reg <= 8'hFF;
            end
            else
            begin
                // Open drain: a one releases the pin entirely
                out_reg  <= 8'h00;
                oe_reg   <= ~src;
                weak_reg <= 8'h00;
            end
        end
    end

endmodule : ppio_drv

// ---- sim/ppio_pin_model.sv ----
// Pin, load and external source model for ports 0 to 5
module ppio_pin_model (
    input  wire logic        pclk,     // Clock
    input  wire logic [47:0] pin_out,  // Block output level
    input  wire logic [47:0] pin_oe,   // Block output enable
    input  wire logic [47:0] weak_pu,  // Block weak pullup
    input  wire logic [47:0] ext_en,   // External source enable
    input  wire logic [47:0] ext_val,  // External source level
    output logic      [47:0] pin_in    // Resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [47:0] flt_reg;              // Level of undriven lines

    // An undriven line must not look stable, so it toggles every clock
    initial flt_reg = 48'h0;
    always @(posedge pclk) flt_reg <= ~flt_reg;

    // Block driver wins, then external source, then pullup or float
    assign pin_in = (pin_oe & pin_out)
                  | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (weak_pu | flt_reg & ~weak_pu));
endmodule : ppio_pin_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the parallel port I/O block
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("ERROR %0t got %h exp %h", $time, (g), (e)); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, port6_in, addr_hi, ad_lo, ad_in, alt_out, alt_in;
    logic [31:0] pwdata, prdata;
    logic [47:0] pin_in, pin_out, pin_oe, weak_pu, ext_en, ext_val;
    logic        ext_n, pc_above_int, mem_cycle, addr16, ad_drive;
    logic [33:0] exp_q[$];
    logic [33:0] mon_e;
    logic [7:0]  lat, alt, hi, lo, p2, m;
    logic [2:0]  b;
    logic        c;
    int          fail_count, n_compared;

    ppio_top i_ppio_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .weak_pu(weak_pu),
        .port6_in(port6_in), .external_access_pin_n(ext_n),
        .pc_above_int(pc_above_int), .mem_cycle(mem_cycle),
        .addr16(addr16), .addr_hi(addr_hi), .ad_lo(ad_lo),
        .ad_drive(ad_drive), .ad_in(ad_in), .alt_out(alt_out),
        .alt_in(alt_in)
    );

    ppio_pin_model i_ppio_pin_model (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .weak_pu(weak_pu), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in)
    );

    ////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // One APB transfer; the expected answer is queued first
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back({~w, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic err);
        apb(1'b1, a, {24'h0, d}, {err, 32'h0});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic err);
        apb(1'b0, a, 32'h0, {err, 24'h0, d});
    endtask : rd

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////
    // Answer monitor: each completed transfer takes the oldest note
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            mon_e = exp_q.pop_front();
            `CHK(pslverr, mon_e[32])
            if (mon_e[33]) `CHK(prdata, mon_e[31:0])
        end
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end

    ////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {port6_in, addr_hi, ad_lo, ext_en, ext_val} = '0;
        {pc_above_int, mem_cycle, addr16, ad_drive} = '0;
        ext_n = 1'b1;
        alt_out = 8'hFF;
        void'($urandom(71));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 `CHK(pin_in[47:8], {40{1'b1}})
        `CHK(pin_oe[7:0], 8'h00)
        for (int i = 0; i < 6; i++)
            rd(8'(8'h20 + 4 * i), 8'hFF, 1'b0);
        rd(8'h40, 8'h00, 1'b1);
        wr(8'h18, 8'h5A, 1'b1);
        // Bits in m stand for analog use and carry noise
        lat = 8'($urandom);
        m = 8'($urandom);
        alt = 8'($urandom) & m;
        port6_in <= lat ^ alt;
        rd(8'h18, lat ^ alt, 1'b0);
        #1 `CHK(prdata[7:0] & ~m, lat & ~m)
        $display("test reset done");

        // Rising port 1 uses the strong pullup only in the first two phases
        wr(8'h04, 8'h00, 1'b0);
        wr(8'h04, 8'hFF, 1'b0);
        #1 `CHK(pin_in[15:8], 8'h00)
        @(posedge pclk);
        #1 `CHK(pin_oe[15:8], 8'hFF)
        `CHK(pin_out[15:8], 8'hFF)
        repeat (2) @(posedge pclk);
        #1 `CHK(pin_oe[15:8], 8'h00)
        `CHK(weak_pu[15:8], 8'hFF)
        m = 8'($urandom);
        ext_en[15:8] <= m;
        rd(8'h04, ~m, 1'b0);
        rd(8'h24, 8'hFF, 1'b0);
        ext_en <= '0;
        $display("test pullup done");

        // Every single-bit operation rewrites the whole port 4 byte
        lat = 8'($urandom);
        wr(8'h10, lat, 1'b0);
        for (int op = 0; op < 4; op++)
        begin
            b = 3'($urandom);
            c = 1'($urandom);
            apb(1'b1, 8'h38, {23'h0, c, op[1:0], b, 3'h4}, 33'h0);
            lat[b] = (op == 0) ? 1'b0 : (op == 1) ? 1'b1
                   : (op == 2) ? ~lat[b] : c;
            rd(8'h30, lat, 1'b0);
        end
        rd(8'h38, 8'h00, 1'b0);
        $display("test bitop done");

        // Port 3 pins carry latch AND alternate output
        lat = 8'($urandom);
        alt = 8'($urandom);
        alt_out <= alt;
        wr(8'h0C, lat, 1'b0);
        repeat (14) @(posedge pclk);
        #1 `CHK(pin_in[31:24], lat & alt)
        `CHK(alt_in, lat & alt)
        $display("test alternate done");

        // External bus with 16-bit then 8-bit addresses
        wr(8'h00, 8'h00, 1'b0);
        p2 = 8'($urandom);
        wr(8'h08, p2, 1'b0);
        hi = 8'($urandom);
        lo = 8'($urandom);
        addr_hi <= hi;
        ad_lo <= lo;
        ad_drive <= 1'b1;
        addr16 <= 1'b1;
        mem_cycle <= 1'b1;
        repeat (4) @(posedge pclk);
        #1 `CHK(pin_out[7:0], lo)
        `CHK(pin_oe[7:0], 8'hFF)
        `CHK(pin_out[23:16], hi)
        `CHK(pin_oe[23:16], 8'hFF)
        rd(8'h3C, 8'h03, 1'b0);
        rd(8'h20, 8'hFF, 1'b0);
        rd(8'h28, p2, 1'b0);
        mem_cycle <= 1'b0;
        pc_above_int <= 1'b1;
        addr16 <= 1'b0;
        ad_drive <= 1'b0;
        ext_en[7:0] <= 8'hFF;
        ext_val[7:0] <= ~lo;
        repeat (4) @(posedge pclk);
        #1 `CHK(pin_in[23:16], p2)
        `CHK(ad_in, ~lo)
        rd(8'h3C, 8'h01, 1'b0);
        pc_above_int <= 1'b0;
        ext_n <= 1'b0;
        rd(8'h3C, 8'h01, 1'b0);
        ext_n <= 1'b1;
        ext_en <= '0;
        repeat (4) @(posedge pclk);
        #1 `CHK(pin_oe[7:0], 8'h00)
        $display("test bus done");
        wrap_up();
    end
endmodule : tb_top
